/* fsc_sequencer.sv */
`timescale 1ns/1ns
// Operation
// - Order bit 0 sinc4 default, 1 filter_order_sel.
// - Chop off rate is fclk/(1024*divider).
// - Chop off settles 4 or 3 periods.
// - Chop swaps inputs, settles, averages results.
// - Chop rate divides by order*1024*divider.
// - Chop on settles in two periods.
// - Notch bit adds 60 Hz notch at 50 Hz.
// - Continuous mode converts each enabled channel in turn.
// - Done low only with settled valid result.
// - Channel select resets filter, settles; done set high on start from idle, on a data read and one cycle before each commit.
// - Next channel converts while old result readable.
// - Full pass takes settle time times channels.
// - Appended status low nibble holds channel number.
// - Data register read drives done high.
module fsc_sequencer #(
  parameter int P_STEP_CYCLES = fsc_pkg::DIV_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Configuration bits.
  input wire logic i_filter_order_sel,
  input wire logic i_chop_en,
  input wire logic i_sixty_hz_notch_en,
  input wire logic [fsc_pkg::DIV_W-1:0] i_rate_divider,
  input wire logic [fsc_pkg::NUM_CH-1:0] i_channel_enable_bits,
  input wire logic i_append_status_en,
  input wire logic i_continuous_en,
  // Filter datapath side.
  input wire logic [fsc_pkg::DATA_W-1:0] i_filter_sample,
  output logic o_filter_reset,
  output logic o_filter_order_sel_sel,
  output logic o_notch60_en,
  output logic o_input_swap,
  output logic [fsc_pkg::CH_IDX_W-1:0] o_mux_channel,
  // Host side.
  input wire logic i_data_read_done,
  output logic o_conv_done_n,
  output logic [fsc_pkg::DATA_W-1:0] o_data,
  output logic [fsc_pkg::STATUS_W-1:0] o_status_byte,
  output logic o_status_append
);

  // The sequencer walks the enabled channels in index order. Each new channel gets a
  // filter reset and a full settling time, because the filter still holds samples of
  // the previous input and its first outputs would mix the two channels.
  // Next enabled channel strictly after cur, wrapping past the top; returns cur if none other.
  function automatic logic [fsc_pkg::CH_IDX_W-1:0] next_enabled(
    input logic [fsc_pkg::NUM_CH-1:0] en,
    input logic [fsc_pkg::CH_IDX_W-1:0] cur
  );
    logic [fsc_pkg::CH_IDX_W-1:0] idx;
    logic found;
    next_enabled = cur;
    found = 1'b0;
    for (int k = 1; k <= fsc_pkg::NUM_CH; k++) begin
      idx = cur + fsc_pkg::CH_IDX_W'(k);
      if (!found && en[idx]) begin
        next_enabled = idx;
        found = 1'b1;
      end
    end
  endfunction : next_enabled

  // Sequencer state and current channel.
  fsc_pkg::fsc_state_t state;
  fsc_pkg::fsc_state_t next_state;
  logic [fsc_pkg::CH_IDX_W-1:0] channel;
  logic [fsc_pkg::CH_IDX_W-1:0] next_channel;
  // Output periods elapsed since the last filter reset.
  // Three bits are enough, since the longest settling lasts four periods.
  logic [2:0] settle_cnt;
  logic [2:0] next_settle_cnt;
  // Previous filter sample, used for the chop average.
  logic [fsc_pkg::DATA_W-1:0] prev_sample;
  logic [fsc_pkg::DATA_W-1:0] next_prev_sample;
  // Staging costs a cycle of latency but lets the done flag rise one cycle before
  // the data register changes, so a host never reads a word that is being replaced.
  // Result waiting one cycle for the data register, with its channel.
  logic [fsc_pkg::DATA_W-1:0] staged;
  logic [fsc_pkg::DATA_W-1:0] next_staged;
  logic [fsc_pkg::CH_IDX_W-1:0] staged_ch;
  logic [fsc_pkg::CH_IDX_W-1:0] next_staged_ch;
  // Host-visible data register, channel tag and done flag.
  logic [fsc_pkg::DATA_W-1:0] data_reg;
  logic [fsc_pkg::DATA_W-1:0] next_data_reg;
  logic [fsc_pkg::TAG_W-1:0] tag;
  logic [fsc_pkg::TAG_W-1:0] next_tag;
  logic done_n;
  logic next_done_n;
  // Chop polarity and one-cycle filter reset.
  logic swap;
  logic next_swap;
  logic frst;
  logic next_frst;
  // Timing terms.
  logic [2:0] settle_len;
  logic [2:0] mult;
  logic tick;
  logic timer_clear;
  logic single_ch;
  logic active;
  logic [fsc_pkg::DATA_W:0] avg_sum;
  logic [fsc_pkg::DATA_W-1:0] result;
  logic [fsc_pkg::CH_IDX_W-1:0] first_ch;

  // Limitation: a configuration change other than disabling the current channel does not restart a running conversion by
  // itself; the host drops the continuous enable to apply new settings cleanly.
  // Period settings. Chop stretches the period by the filter order and settles in two
  // periods; without chop the period is the base rate and settling is the filter order.
  always_comb begin
    if (i_chop_en) begin
      settle_len = fsc_pkg::SETTLE_CHOP;
      if (i_filter_order_sel == fsc_pkg::ORDER_FILTER_ORDER_SEL) begin
        mult = fsc_pkg::CHOP_MULT_FILTER_ORDER_SEL;
      end else begin
        mult = fsc_pkg::CHOP_MULT_SINC4;
      end
    end else begin
      mult = fsc_pkg::CHOP_MULT_OFF;
      if (i_filter_order_sel == fsc_pkg::ORDER_FILTER_ORDER_SEL) begin
        settle_len = fsc_pkg::SETTLE_FILTER_ORDER_SEL;
      end else begin
        settle_len = fsc_pkg::SETTLE_SINC4;
      end
    end
  end

  // The timer runs free in single channel mode. Its count is not cleared between
  // results, so the output rate stays exactly one result per period.
  // Output period generator, restarted at every filter reset.
  fsc_period_timer #(
    .P_STEP_CYCLES(P_STEP_CYCLES)
  ) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_clear(timer_clear),
    .i_rate_divider(i_rate_divider),
    .i_mult(mult),
    .o_tick(tick)
  );

  // Sequencer next-state logic: channel stepping, settling count, result staging,
  // chop polarity and the done flag.
  always_comb begin
    next_state = state;
    next_channel = channel;
    next_settle_cnt = settle_cnt;
    next_prev_sample = prev_sample;
    next_staged = staged;
    next_staged_ch = staged_ch;
    next_data_reg = data_reg;
    next_tag = tag;
    next_done_n = done_n;
    next_swap = swap;
    next_frst = 1'b0;
    timer_clear = 1'b0;
    single_ch = ($countones(i_channel_enable_bits) == 1);
    active = i_continuous_en && (i_channel_enable_bits != '0);
    first_ch = next_enabled(i_channel_enable_bits, fsc_pkg::CH_IDX_W'(fsc_pkg::NUM_CH - 1));
    // Averaging the two polarities cancels the input offset.
    avg_sum = {1'b0, prev_sample} + {1'b0, i_filter_sample};
    result = i_chop_en ? avg_sum[fsc_pkg::DATA_W:1] : i_filter_sample;

    // A completed read raises done; a commit in the same cycle still wins below.
    if (i_data_read_done) begin
      next_done_n = 1'b1;
    end

    case (state)
      fsc_pkg::FSC_IDLE: begin
        // The timer is held cleared so the first period starts with the filter reset.
        timer_clear = 1'b1;
        if (active) begin
          // Start from the lowest enabled channel with a fresh filter.
          next_channel = first_ch;
          next_frst = 1'b1;
          next_done_n = 1'b1;
          next_settle_cnt = fsc_pkg::SETTLE_CNT_RESET;
          next_swap = 1'b0;
          next_state = fsc_pkg::FSC_SETTLE;
        end
      end
      fsc_pkg::FSC_SETTLE, fsc_pkg::FSC_RUN: begin
        if (!active || !i_channel_enable_bits[channel]) begin
          // Configuration pulled the channel away; go back and restart cleanly.
          next_state = fsc_pkg::FSC_IDLE;
        end else if (tick) begin
          next_prev_sample = i_filter_sample;
          if (i_chop_en) begin
            next_swap = !swap;
          end
          if (state == fsc_pkg::FSC_RUN
              || settle_cnt + 3'h1 >= settle_len) begin
            // Settled: stage the result and warn the host before the update.
            next_staged = result;
            next_staged_ch = channel;
            next_done_n = 1'b1;
            next_state = fsc_pkg::FSC_COMMIT;
          end else begin
            next_settle_cnt = settle_cnt + 3'h1;
          end
        end
      end
      fsc_pkg::FSC_COMMIT: begin
        // The result lands in the data register and done falls together.
        next_data_reg = staged;
        next_tag = fsc_pkg::TAG_W'(staged_ch);
        next_done_n = 1'b0;
        if (!active) begin
          next_state = fsc_pkg::FSC_IDLE;
        end else if (single_ch && i_channel_enable_bits[channel]) begin
          // One channel keeps its filter running and delivers every period.
          next_state = fsc_pkg::FSC_RUN;
        end else begin
          // Move on with the next enabled channel, wrapping to the lowest; the old
          // result stays in the data register meanwhile. A pass is thus settle time
          // times the enabled channel count.
          next_channel = next_enabled(i_channel_enable_bits, channel);
          next_frst = 1'b1;
          timer_clear = 1'b1;
          next_settle_cnt = fsc_pkg::SETTLE_CNT_RESET;
          next_swap = 1'b0;
          next_state = fsc_pkg::FSC_SETTLE;
        end
      end
      default: begin
        // Unused state codes fall back to idle and restart cleanly.
        next_state = fsc_pkg::FSC_IDLE;
      end
    endcase
  end

  // All sequencer state shares one asynchronous reset. After reset the done flag is
  // high, so a host polling it straight after power-up never reads a stale zero.
  // Sequencer registers.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= fsc_pkg::FSC_IDLE;
      channel <= '0;
      settle_cnt <= fsc_pkg::SETTLE_CNT_RESET;
      prev_sample <= fsc_pkg::DATA_RESET;
      staged <= fsc_pkg::DATA_RESET;
      staged_ch <= '0;
      data_reg <= fsc_pkg::DATA_RESET;
      tag <= fsc_pkg::TAG_RESET;
      done_n <= 1'b1;
      swap <= 1'b0;
      frst <= 1'b0;
    end else begin
      state <= next_state;
      channel <= next_channel;
      settle_cnt <= next_settle_cnt;
      prev_sample <= next_prev_sample;
      staged <= next_staged;
      staged_ch <= next_staged_ch;
      data_reg <= next_data_reg;
      tag <= next_tag;
      done_n <= next_done_n;
      swap <= next_swap;
      frst <= next_frst;
    end
  end

  // Filter configuration registers. The notch itself is shaped by the filter; the
  // sequencer only carries the enable, which takes effect whatever the rate.
  logic filter_order_sel_q;
  logic notch_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      filter_order_sel_q <= fsc_pkg::ORDER_SINC4;
      notch_q <= 1'b0;
    end else begin
      filter_order_sel_q <= (i_filter_order_sel == fsc_pkg::ORDER_FILTER_ORDER_SEL);
      notch_q <= i_sixty_hz_notch_en;
    end
  end

  // Every output below is a register copy, or the status byte built from registers, except the append flag, which
  // is a plain wire; the host samples it together with the data, so no extra delay
  // is wanted there.
  // Output drive.
  assign o_filter_reset = frst;
  assign o_filter_order_sel_sel = filter_order_sel_q;
  assign o_notch60_en = notch_q;
  assign o_input_swap = swap;
  assign o_mux_channel = channel;
  assign o_conv_done_n = done_n;
  assign o_data = data_reg;
  assign o_status_byte = {done_n, 3'h0, tag};
  assign o_status_append = i_append_status_en;

endmodule : fsc_sequencer

/* fsc_pkg.sv */
package fsc_pkg;

  // Number of channel enable bits and width of the channel tag in the status byte.
  localparam int NUM_CH = 8;
  localparam int CH_IDX_W = 3;
  localparam int TAG_W = 4;

  // Width of a conversion result, of the status byte and of the rate divider.
  localparam int DATA_W = 24;
  localparam int STATUS_W = 8;
  localparam int DIV_W = 10;

  // Width of the per-period cycle counter; holds 4 * 1024 * 1023 with room to spare.
  localparam int PER_W = 24;

  // Master clock cycles per rate divider step; the output period is this times the divider, and times the order with chop.
  localparam int DIV_STEP_CYCLES = 1024;

  // Master clock rate of this block.
  localparam int CLK_HZ = 50_000_000;

  // Filter order select encoding.
  localparam logic ORDER_SINC4 = 1'b0;
  localparam logic ORDER_FILTER_ORDER_SEL = 1'b1;

  // Settling time in output periods, and the chop period multiplier per filter order.
  localparam logic [2:0] SETTLE_SINC4 = 3'h4;
  localparam logic [2:0] SETTLE_FILTER_ORDER_SEL = 3'h3;
  localparam logic [2:0] SETTLE_CHOP = 3'h2;
  localparam logic [2:0] CHOP_MULT_SINC4 = 3'h4;
  localparam logic [2:0] CHOP_MULT_FILTER_ORDER_SEL = 3'h3;
  localparam logic [2:0] CHOP_MULT_OFF = 3'h1;

  // Smallest legal divider; zero is treated as this value.
  localparam logic [DIV_W-1:0] DIV_MIN = 10'h001;

  // Reset values.
  localparam logic [DATA_W-1:0] DATA_RESET = 24'h000000;
  localparam logic [TAG_W-1:0] TAG_RESET = 4'h0;
  localparam logic [2:0] SETTLE_CNT_RESET = 3'h0;

  // Sequencer states.
  typedef enum logic [1:0] {
    FSC_IDLE,
    FSC_SETTLE,
    FSC_RUN,
    FSC_COMMIT
  } fsc_state_t;

endpackage : fsc_pkg

/* fsc_period_timer.sv */
`timescale 1ns/1ns
// Counts one output-rate period of rate_divider * step * multiplier master clocks.
module fsc_period_timer #(
  parameter int P_STEP_CYCLES = fsc_pkg::DIV_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Control.
  input wire logic i_clear,
  input wire logic [fsc_pkg::DIV_W-1:0] i_rate_divider,
  input wire logic [2:0] i_mult,
  // Period boundary.
  output logic o_tick
);

  // Cycle count within the current period.
  logic [fsc_pkg::PER_W-1:0] cnt;
  logic [fsc_pkg::PER_W-1:0] next_cnt;
  // Last cycle index of the period.
  logic [fsc_pkg::PER_W-1:0] last;
  // Divider with zero forced up to the smallest legal value.
  logic [fsc_pkg::DIV_W-1:0] div_eff;

  // The period length is recomputed every cycle, so a divider change takes effect
  // at once; a shortened period ends on the first cycle the counter is at or past it.
  always_comb begin
    div_eff = (i_rate_divider == '0) ? fsc_pkg::DIV_MIN : i_rate_divider;
    last = fsc_pkg::PER_W'(div_eff) * fsc_pkg::PER_W'(P_STEP_CYCLES)
           * fsc_pkg::PER_W'(i_mult) - fsc_pkg::PER_W'(1);
    o_tick = !i_clear && (cnt >= last);
    if (i_clear || o_tick) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + fsc_pkg::PER_W'(1);
    end
  end

  // Counter register.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : fsc_period_timer

/* fsc_chk_sva.sv */
`timescale 1ns/1ns
// Timing checks on the sequencer ports; periods are rebuilt from the live configuration.
module fsc_chk #(
  parameter int P_STEP_CYCLES = fsc_pkg::DIV_STEP_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_filter_order_sel,
  input wire logic i_chop_en,
  input wire logic i_sixty_hz_notch_en,
  input wire logic [fsc_pkg::DIV_W-1:0] i_rate_divider,
  input wire logic i_append_status_en,
  input wire logic i_data_read_done,
  input wire logic o_filter_reset,
  input wire logic o_filter_order_sel_sel,
  input wire logic o_notch60_en,
  input wire logic o_conv_done_n,
  input wire logic [fsc_pkg::DATA_W-1:0] o_data,
  input wire logic [fsc_pkg::STATUS_W-1:0] o_status_byte,
  input wire logic o_status_append
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic [31:0] per;  // Clocks between results.
  logic [31:0] sp;  // Clocks of a full settle.
  logic [31:0] cnt;  // Clocks since the last reset pulse or settled result.
  logic first;  // A channel reset is waiting for its first result.
  // Chop stretches the period by the order, then settles in two periods.
  always_comb begin
    per = 32'(i_rate_divider) * P_STEP_CYCLES;
    sp = per * (i_filter_order_sel ? 32'h3 : 32'h4);
    if (i_chop_en) begin
      per = sp;
      sp = per * 32'h2;
    end
  end
  // A fall just after a reset pulse belongs to the old channel, so it is skipped.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 32'h0;
      first <= 1'b0;
    end else if (o_filter_reset) begin
      cnt <= 32'h1;
      first <= 1'b1;
    end else if ($fell(o_conv_done_n) && cnt > 32'h2) begin
      cnt <= 32'h1;
      first <= 1'b0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
  a_reset_pulse: assert property (o_filter_reset |=> !o_filter_reset)
    else $error("filter reset held too long");
  // On a channel change the old channel's result may stay ready while the filter resets.
  a_reset_done: assert property (
    o_filter_reset |-> o_conv_done_n || $fell(o_conv_done_n))
    else $error("ready during channel reset");
  a_read_clears: assert property (i_data_read_done && !o_conv_done_n |=> o_conv_done_n)
    else $error("ready kept after read");
  a_data_hold: assert property ((!o_conv_done_n ##1 !o_conv_done_n) |-> $stable(o_data))
    else $error("data moved while ready");
  a_status_flag: assert property (o_status_byte[7:4] == {o_conv_done_n, 3'h0})
    else $error("status high bits wrong");
  a_append_copy: assert property (o_status_append == i_append_status_en)
    else $error("append flag wrong");
  a_order_sel: assert property (o_filter_order_sel_sel == $past(i_filter_order_sel))
    else $error("filter order wrong");
  a_notch_copy: assert property (o_notch60_en == $past(i_sixty_hz_notch_en))
    else $error("notch enable wrong");
  a_settle_time: assert property (
    $fell(o_conv_done_n) && first && cnt > 32'h2 |-> cnt + 32'h2 >= sp && cnt <= sp + 32'h4)
    else $error("first result settle time wrong");
  a_result_period: assert property (
    $fell(o_conv_done_n) && !first |-> cnt == per)
    else $error("result period wrong");
  cover property ($fell(o_conv_done_n) && !first && i_chop_en);
  cover property (o_filter_reset && o_filter_order_sel_sel);
  cover property (i_data_read_done && !o_conv_done_n);
endmodule : fsc_chk

/* fsc_host.sv */
`timescale 1ns/1ns
// Host that reads a ready result once it has stayed ready for a chosen number of clocks.
module fsc_host (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Ready flag and read pacing.
  input wire logic i_conv_done_n,
  input wire logic [3:0] i_delay,
  // Read completion pulse.
  output logic o_read_done
);
  logic [3:0] wait_cnt;  // Clocks spent waiting on the current result.
  // A slow host may read late; the pulse is one clock, then it waits for a new result.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_read_done <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      o_read_done <= 1'b0;
      if (i_conv_done_n || o_read_done) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == i_delay) begin
        o_read_done <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : fsc_host

/* fsc_sequencer_tb.sv */
`timescale 1ns/1ns
module fsc_sequencer_tb;
  logic clk, nrst, order, chop, notch, app, cont, rd, freset, filter_order_sel, notch_o, swap, done_n, sapp;
  logic [9:0] div;
  logic [7:0] en, status;
  logic [23:0] sample, data;
  logic [2:0] mux;
  logic [3:0] dly;
  int num_errors = 0;
  int n_tests = 0;
  int nres = 0;
  int cyc = 0;
  fsc_sequencer #(.P_STEP_CYCLES(4)) dut_u (.i_ref_clk(clk), .i_nrst(nrst),
    .i_filter_order_sel(order), .i_chop_en(chop), .i_sixty_hz_notch_en(notch),
    .i_rate_divider(div), .i_channel_enable_bits(en), .i_append_status_en(app),
    .i_continuous_en(cont), .i_filter_sample(sample), .o_filter_reset(freset),
    .o_filter_order_sel_sel(filter_order_sel), .o_notch60_en(notch_o), .o_input_swap(swap), .o_mux_channel(mux),
    .i_data_read_done(rd), .o_conv_done_n(done_n), .o_data(data), .o_status_byte(status),
    .o_status_append(sapp));
  fsc_host host_u (.i_ref_clk(clk), .i_nrst(nrst), .i_conv_done_n(done_n), .i_delay(dly),
    .o_read_done(rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The filter output ramps by one each clock, so an averaged result sits half a period back.
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) sample <= 24'(cyc);
  always @(posedge clk) if (freset === 1'b1) nres++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // Idles the sequencer, applies a new setup and restarts it.
  task automatic setup(input logic o, input logic c, input logic [9:0] d, input logic [7:0] e);
    cont = 1'b0;
    repeat (2) @(negedge clk);
    order = o;
    chop = c;
    notch = d[1];
    div = d;
    en = e;
    dly = o ? 4'h9 : 4'h0;
    cont = 1'b1;
  endtask : setup
  // Counts clocks until the ready flag falls anew; bounded so a hang is reported.
  task automatic wait_result(output int gap);
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (done_n !== 1'b1 && gap < 3000);
    while (done_n !== 1'b0 && gap < 3000) begin
      @(negedge clk);
      gap++;
    end
    if (gap >= 3000) check("timeout", 0, 1);
  endtask : wait_result
  initial begin
    int g, s, p, lo;
    logic sw;
    logic [3:0] seq [3];
    seq = '{4'h0, 4'h2, 4'h5};
    {order, chop, notch, app, cont} = 5'h00;
    div = 10'h001;
    en = 8'h00;
    dly = 4'h0;
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    check("done_n", done_n, 1);
    check("data", data, 0);
    check("status", status, 8'h80);
    // Every order, chop and divider pairing on one channel.
    for (int i = 0; i < 8; i++) begin
      setup(i[0], i[2], i[1] ? 10'h002 : 10'h001, 8'h08);
      p = div * 4 * (chop ? (order ? 3 : 4) : 1);
      s = chop ? 2 : (order ? 3 : 4);
      wait_result(g);
      check("settle", g >= s * p && g <= s * p + 5, 1);
      check("filter_order_sel", filter_order_sel, order);
      check("notch", notch_o, notch);
      check("tag", status[3:0], 3);
      sw = swap;
      lo = nres;
      wait_result(g);
      check("period", g, p);
      check("resets", nres - lo, 0);
      check("swap", sw ^ swap, chop);
      // Sample taken at the tick, staged one clock, committed the next: two clocks back.
      check("average", cyc - int'(data), 2 + (chop ? p / 2 : 0));
    end
    // Three channels, wrapping from the highest back to the lowest.
    app = 1'b1;
    setup(1'b0, 1'b0, 10'h001, 8'h25);
    lo = nres;
    for (int k = 0; k < 5; k++) begin
      wait_result(g);
      check("tag", status[3:0], seq[k % 3]);
      check("next", mux, seq[(k + 1) % 3]);
      if (k > 0) check("slot", g >= 16 && g <= 21, 1);
    end
    // The pulse of the last channel change is still standing and not yet counted.
    check("resets", nres - lo, 5);
    check("reset pulse", freset, 1);
    check("append", sapp, 1);
    // Reset again in mid-run.
    repeat (7) @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    check("done_n", done_n, 1);
    check("data", data, 0);
    nrst = 1'b1;
    // The sequencer restarts from the lowest enabled channel with a fresh filter.
    @(negedge clk);
    check("restart", freset, 1);
    check("first ch", mux, 0);
    check("done_n", done_n, 1);
    wait_result(g);
    check("tag", status[3:0], 0);
    end_sim();
  end
  initial begin
    #200_000;
    num_errors++;
    end_sim();
  end
endmodule : fsc_sequencer_tb
bind fsc_sequencer fsc_chk #(.P_STEP_CYCLES(P_STEP_CYCLES)) chk_u (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_filter_order_sel(i_filter_order_sel),
  .i_chop_en(i_chop_en), .i_sixty_hz_notch_en(i_sixty_hz_notch_en),
  .i_rate_divider(i_rate_divider), .i_append_status_en(i_append_status_en),
  .i_data_read_done(i_data_read_done), .o_filter_reset(o_filter_reset),
  .o_filter_order_sel_sel(o_filter_order_sel_sel), .o_notch60_en(o_notch60_en), .o_conv_done_n(o_conv_done_n),
  .o_data(o_data), .o_status_byte(o_status_byte), .o_status_append(o_status_append));
